// [inc/dmst_pkg.sv]
// package: constants and types of the decoder master sync timing block
// Behaviour
// R1 - pixel clock is the master oscillator divided by two
// R2 - picture sync resynchronises the clock divider chain
// R3 - pixel counter runs 612 pixels; line load strobe during pixel 612
// R4 - pixel address is zero right after the line load strobe ends
// R5 - pixels 0 to 99 are horizontal blanking, next 512 active video
// R6 - picture sync resets pixel counter and the composite sync generator
// R7 - one transform clock set per segment; rate follows resolution
// R8 - segment pixel counter gives the 5-bit output select address
// R9 - the same address addresses the offset correction memory
// R10 - resolution mode picks segment start value and transform clock rate
// R11 - in horizontal blanking line number replaces address; force mid-grey
// R12 - output section runs at full, half or quarter pixel rate
// R13 - offset loop: comparator, up/down counter, 64 x 9 memory
// R14 - in active video the memory output follows each pixel
// R15 - offset memory updated once per line in blanking, held while active
// R16 - mode word selects one of three reconstruction filters
// R17 - line counter runs 525 lines; clear strobe during line 525
// R18 - line address is zero right after the clear strobe ends
// R19 - 21 blank, 240 field 1, 23 blank, 240 field 2, last line blank
// R20 - picture sync resets the line counter
// R21 - control memory load strobe during field 1 vertical blanking
// R22 - mid-grey start strobe once per field; write inhibit for 128 mode
// R23 - 128 mode inhibits line memory writes on alternate lines
// R24 - offset counter steps one by comparator polarity, then written back
package dmst_pkg;
  localparam int OSC_KHZ = 19278;
  localparam int PIX_KHZ = OSC_KHZ / 2;

  localparam logic [9:0] PIX_LAST     = 10'h263;
  localparam logic [9:0] HBLANK_PIX   = 10'h064;
  localparam logic [9:0] LINE_LAST    = 10'h20C;
  localparam logic [9:0] F1_START     = 10'h015;
  localparam logic [9:0] F1_END       = 10'h105;
  localparam logic [9:0] F2_START     = 10'h11C;
  localparam logic [9:0] OFS_MEAS_PIX = 10'h03C;

  localparam logic [4:0] SEG_LAST      = 5'h1F;
  localparam logic [4:0] SEG_START_512 = 5'h00;
  localparam logic [4:0] SEG_START_256 = 5'h00;
  localparam logic [4:0] SEG_START_128 = 5'h00;
  localparam logic [1:0] OUT_DIV_512   = 2'h0;
  localparam logic [1:0] OUT_DIV_256   = 2'h1;
  localparam logic [1:0] OUT_DIV_128   = 2'h3;

  localparam int         OFS_AW    = 6;
  localparam int         OFS_W     = 9;
  localparam int         OFS_DEPTH = 64;
  localparam logic [8:0] OFS_MID   = 9'h100;
  localparam logic [8:0] OFS_MAX   = 9'h1FF;
  localparam logic [8:0] OFS_MIN   = 9'h000;

  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_POS    = 12'h008;
  localparam int          CTRL_W     = 3;
  localparam int          CTRL_INTERP = 2;
  localparam logic [2:0]  CTRL_RESET = 3'h0;

  typedef enum logic [1:0] {RES_512, RES_256, RES_128} dmst_res_e;
endpackage

// [rtl/dmst_ofs_mem.sv]
// offset correction memory, registered read data
`timescale 1ns/10ps
module dmst_ofs_mem (
  input  wire logic                           pclk,
  input  wire logic                           we,
  input  wire logic [dmst_pkg::OFS_AW-1:0]    addr,
  input  wire logic [dmst_pkg::OFS_W-1:0]     wdata,
  output logic      [dmst_pkg::OFS_W-1:0]     rdata_ff
);
  import dmst_pkg::*;

  logic [OFS_W-1:0] mem [0:OFS_DEPTH-1];

  // no reset: contents are tracked as valid by the owner
  always_ff @(posedge pclk)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
    rdata_ff <= mem[addr];
  end
endmodule

// [rtl/dmst_timing.sv]
// decoder master sync timing generator with apb control
`timescale 1ns/10ps
module dmst_timing (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        master_osc,
  input  wire logic        picture_sync,
  input  wire logic        comp_above,
  output logic             pixel_clk,
  output logic             pll_div_resync,
  output logic             tv_sync_reset,
  output logic [9:0]       pixel_addr,
  output logic [9:0]       line_addr,
  output logic             line_load_strobe,
  output logic             line_counter_clear_strobe,
  output logic             hblank,
  output logic             vblank,
  output logic             active_video,
  output logic             field2,
  output logic             seg_clk,
  output logic [4:0]       seg_addr,
  output logic             midgrey_force,
  output logic             out_sample_strobe,
  output logic [1:0]       filter_select,
  output logic [dmst_pkg::OFS_W-1:0] correction_value,
  output logic             control_ram_load,
  output logic             field_midgrey_start,
  output logic             line_memory_write_inhibit
);
  import dmst_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                 osc_d;
    logic                 div;
    logic                 pll_resync;
    logic                 tv_reset;
    logic [9:0]           pix;
    logic [9:0]           line;
    logic                 lls;
    logic                 lcs;
    logic                 hblank;
    logic                 vblank;
    logic                 active;
    logic                 field2;
    logic [1:0]           out_div;
    logic [4:0]           seg;
    logic                 seg_clk;
    logic [4:0]           seg_addr;
    logic                 midgrey;
    logic                 out_strobe;
    logic [1:0]           filter;
    logic [OFS_AW-1:0]    mem_addr;
    logic                 mem_we;
    logic [OFS_W-1:0]     mem_wdata;
    logic [OFS_DEPTH-1:0] valid;
    logic                 rd_valid;
    logic [OFS_W-1:0]     corr;
    logic                 ram_load;
    logic                 midgrey_start;
    logic                 wr_inhibit;
    logic [CTRL_W-1:0]    ctrl;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
  } dmst_state_s;

  dmst_state_s      st_ff;
  dmst_state_s      nxt_st;
  logic [OFS_W-1:0] mem_rdata;
  logic             osc_edge;
  logic             pix_tick;
  logic             last_pix;
  dmst_res_e        res;
  logic [1:0]       out_limit;
  logic [4:0]       seg_start;
  logic [OFS_W-1:0] ofs_now;
  logic [OFS_W-1:0] ofs_adj;

  dmst_ofs_mem u_mem (
    .pclk     (pclk),
    .we       (st_ff.mem_we),
    .addr     (st_ff.mem_addr),
    .wdata    (st_ff.mem_wdata),
    .rdata_ff (mem_rdata)
  );

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  always_comb
  begin
    unique case (st_ff.ctrl[1:0])
      2'h1:
      begin
        res       = RES_256;
        out_limit = OUT_DIV_256;
        seg_start = SEG_START_256;
      end
      2'h2:
      begin
        res       = RES_128;
        out_limit = OUT_DIV_128;
        seg_start = SEG_START_128;
      end
      // code 3 is illegal and falls back to full resolution
      default:
      begin
        res       = RES_512;
        out_limit = OUT_DIV_512;
        seg_start = SEG_START_512;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    osc_edge = master_osc & ~st_ff.osc_d;
    pix_tick = osc_edge & st_ff.div;
    last_pix = (st_ff.pix == PIX_LAST);
    ofs_now  = st_ff.rd_valid ? mem_rdata : OFS_MID;
    ofs_adj  = ofs_now;
    if (comp_above && ofs_now != OFS_MIN)
    begin
      ofs_adj = ofs_now - 9'h001;
    end
    else if (!comp_above && ofs_now != OFS_MAX)
    begin
      ofs_adj = ofs_now + 9'h001;
    end

    nxt_st.osc_d      = master_osc;
    nxt_st.pll_resync = 1'b0;
    nxt_st.tv_reset   = 1'b0;
    nxt_st.seg_clk    = 1'b0;
    nxt_st.out_strobe = 1'b0;
    nxt_st.mem_we     = 1'b0;

    if (osc_edge)
    begin
      nxt_st.div = ~st_ff.div; // [R1]
    end

    if (picture_sync)
    begin
      nxt_st.div        = 1'b0; // [R2]
      nxt_st.pll_resync = 1'b1; // [R2]
      nxt_st.pix        = 10'h000; // [R6]
      nxt_st.tv_reset   = 1'b1; // [R6]
      nxt_st.line       = 10'h000; // [R20]
      nxt_st.out_div    = 2'h0;
      nxt_st.seg        = seg_start;
    end
    else if (pix_tick)
    begin
      nxt_st.pix = last_pix ? 10'h000 : st_ff.pix + 10'h001; // [R3] [R4]
      if (st_ff.active)
      begin
        // output rate divides the pixel clock per resolution; last pixel too
        if (st_ff.out_div == out_limit)
        begin
          nxt_st.out_div    = 2'h0; // [R10] [R12]
          nxt_st.out_strobe = 1'b1; // [R12]
          nxt_st.seg        = st_ff.seg + 5'h01; // [R8]
          nxt_st.seg_clk    = (st_ff.seg == SEG_LAST); // [R7]
        end
        else
        begin
          nxt_st.out_div = st_ff.out_div + 2'h1;
        end
      end
      if (last_pix)
      begin
        nxt_st.line    = (st_ff.line == LINE_LAST) ? 10'h000 : st_ff.line + 10'h001; // [R17] [R18]
        nxt_st.seg     = seg_start; // [R10]
        nxt_st.out_div = 2'h0;
      end
      // one measurement per line, late enough for the read to settle
      if (st_ff.hblank && st_ff.pix == OFS_MEAS_PIX)
      begin
        nxt_st.mem_we    = 1'b1; // [R13] [R15] [R24]
        nxt_st.mem_wdata = ofs_adj; // [R24]
        nxt_st.corr      = ofs_adj;
      end
    end

    if (st_ff.mem_we)
    begin
      nxt_st.valid[st_ff.mem_addr] = 1'b1; // [R13]
    end

    // decodes taken from the next counter values so outputs agree
    nxt_st.lls      = (nxt_st.pix == PIX_LAST); // [R3]
    nxt_st.lcs      = (nxt_st.line == LINE_LAST); // [R17]
    nxt_st.hblank   = (nxt_st.pix < HBLANK_PIX); // [R5]
    nxt_st.active   = ~nxt_st.hblank; // [R5]
    nxt_st.vblank   = (nxt_st.line < F1_START) | nxt_st.lcs
                    | ((nxt_st.line >= F1_END) & (nxt_st.line < F2_START)); // [R19]
    nxt_st.field2   = (nxt_st.line >= F1_END) & ~nxt_st.lcs; // [R19]
    nxt_st.seg_addr = nxt_st.hblank ? nxt_st.line[4:0] : nxt_st.seg; // [R8] [R11]
    nxt_st.midgrey  = nxt_st.hblank; // [R11]
    nxt_st.filter   = res; // [R16]
    // address held during the write so the write hits the measured entry
    if (!nxt_st.mem_we && !st_ff.mem_we)
    begin
      nxt_st.mem_addr = nxt_st.hblank ? nxt_st.line[OFS_AW-1:0]
                                      : {1'b0, nxt_st.seg}; // [R9] [R11] [R14]
    end
    nxt_st.rd_valid = st_ff.valid[st_ff.mem_addr];
    if (st_ff.active)
    begin
      nxt_st.corr = ofs_now; // [R14]
    end
    nxt_st.ram_load      = (nxt_st.line < F1_START); // [R21]
    nxt_st.midgrey_start = (nxt_st.line == 10'h000) | (nxt_st.line == F1_END); // [R22]
    // interpolation halves the unpacker output on odd lines only
    nxt_st.wr_inhibit    = (res == RES_128) & st_ff.ctrl[CTRL_INTERP]
                         & nxt_st.line[0]; // [R22] [R23]

    // --------------------------------------------------------------
    // apb slave: one wait state, write lands when pready is seen
    // --------------------------------------------------------------
    nxt_st.pready  = 1'b0;
    nxt_st.pslverr = 1'b0;
    if (psel && penable && !st_ff.pready)
    begin
      nxt_st.pready = 1'b1;
      unique case (paddr)
        REG_CTRL:
          nxt_st.prdata = {29'h0000000, st_ff.ctrl};
        REG_STATUS:
          nxt_st.prdata = {24'h000000, 2'h0, st_ff.filter, st_ff.field2,
                           st_ff.active, st_ff.vblank, st_ff.hblank};
        REG_POS:
          nxt_st.prdata = {6'h00, st_ff.line, 6'h00, st_ff.pix};
        default:
        begin
          nxt_st.prdata  = 32'h00000000;
          nxt_st.pslverr = 1'b1;
        end
      endcase
    end
    if (psel && penable && st_ff.pready && pwrite && paddr == REG_CTRL)
    begin
      nxt_st.ctrl = pwdata[CTRL_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff          <= '0;
      st_ff.hblank   <= 1'b1;
      st_ff.vblank   <= 1'b1;
      st_ff.midgrey  <= 1'b1;
      st_ff.ram_load <= 1'b1;
      st_ff.midgrey_start <= 1'b1;
      st_ff.ctrl     <= CTRL_RESET;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata                    = st_ff.prdata;
  assign pready                    = st_ff.pready;
  assign pslverr                   = st_ff.pslverr;
  assign pixel_clk                 = st_ff.div;
  assign pll_div_resync            = st_ff.pll_resync;
  assign tv_sync_reset             = st_ff.tv_reset;
  assign pixel_addr                = st_ff.pix;
  assign line_addr                 = st_ff.line;
  assign line_load_strobe          = st_ff.lls;
  assign line_counter_clear_strobe = st_ff.lcs;
  assign hblank                    = st_ff.hblank;
  assign vblank                    = st_ff.vblank;
  assign active_video              = st_ff.active;
  assign field2                    = st_ff.field2;
  assign seg_clk                   = st_ff.seg_clk;
  assign seg_addr                  = st_ff.seg_addr;
  assign midgrey_force             = st_ff.midgrey;
  assign out_sample_strobe         = st_ff.out_strobe;
  assign filter_select             = st_ff.filter;
  assign correction_value          = st_ff.corr;
  assign control_ram_load          = st_ff.ram_load;
  assign field_midgrey_start       = st_ff.midgrey_start;
  assign line_memory_write_inhibit = st_ff.wr_inhibit;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_osc_halving: assert property (osc_edge && !picture_sync |=> st_ff.div != $past(st_ff.div)) // [R1]
    else $error("pixel clock did not toggle on oscillator edge");

  a_pix_wrap: assert property (st_ff.lls && pix_tick && !picture_sync
                               |=> st_ff.pix == 10'h000 && !st_ff.lls) // [R3]
    else $error("pixel counter did not wrap after line load");

  a_pix_bound: assert property (st_ff.pix <= PIX_LAST && st_ff.lls == (st_ff.pix == PIX_LAST)) // [R4]
    else $error("pixel counter out of range or strobe misplaced");

  a_hblank_map: assert property (st_ff.hblank == (st_ff.pix < HBLANK_PIX) && st_ff.active != st_ff.hblank) // [R5]
    else $error("blanking window wrong");

  a_sync_reset: assert property (picture_sync
                                 |=> st_ff.pix == 10'h000 && st_ff.line == 10'h000
                                     && st_ff.tv_reset && st_ff.pll_resync) // [R6]
    else $error("picture sync did not reset counters");

  a_line_wrap: assert property (st_ff.lcs && st_ff.lls && pix_tick && !picture_sync
                                |=> st_ff.line == 10'h000 && !st_ff.lcs) // [R18]
    else $error("line counter did not clear after last line");

  a_blank_addr: assert property (st_ff.hblank |-> st_ff.seg_addr == st_ff.line[4:0] && st_ff.midgrey) // [R11]
    else $error("blanking address is not the line number");

  a_ofs_write: assert property (st_ff.mem_we |-> st_ff.hblank && !$past(st_ff.mem_we)) // [R15]
    else $error("offset memory written outside blanking");

  a_ofs_step: assert property (st_ff.mem_we && st_ff.rd_valid
                               |-> (st_ff.mem_wdata == mem_rdata + 9'h001)
                                   || (st_ff.mem_wdata == mem_rdata - 9'h001)
                                   || (st_ff.mem_wdata == mem_rdata)) // [R24]
    else $error("offset counter stepped by more than one");

  a_inhibit: assert property (st_ff.wr_inhibit |-> st_ff.filter == RES_128 && st_ff.line[0]) // [R23]
    else $error("write inhibit outside interpolated mode");

  a_apb_pulse: assert property (st_ff.pready |=> !st_ff.pready)
    else $error("pready held longer than one cycle");
endmodule

// [testbench/dmst_far_model.sv]
// far side model: oscillator, memory synchronizer picture sync, offset comparator
`timescale 1ns/10ps
module dmst_far_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic sync_req,
  input  wire logic comp_level,
  output logic      master_osc,
  output logic      picture_sync,
  output logic      comp_above
);
  // ----------------------------------------
  // oscillator and sync drive
  // ----------------------------------------
  // fastest legal oscillator: low one pclk between rising edges keeps the run short
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      master_osc   <= 1'b0;
      picture_sync <= 1'b0;
      comp_above   <= 1'b0;
    end
    else
    begin
      master_osc   <= ~master_osc;
      picture_sync <= sync_req;
      comp_above   <= comp_level;
    end
  end
endmodule

// [testbench/tb_decoder_master_sync_timing.sv]
// self-checking bench for the decoder master sync timing block
`timescale 1ns/10ps
module tb_decoder_master_sync_timing;
  import dmst_pkg::*;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata;
  logic              master_osc, picture_sync, comp_above, sync_req, comp_level;
  logic              pixel_clk, pll_div_resync, tv_sync_reset, line_load_strobe, line_counter_clear_strobe;
  logic              hblank, vblank, active_video, field2, seg_clk, midgrey_force, out_sample_strobe;
  logic              control_ram_load, field_midgrey_start, line_memory_write_inhibit;
  logic [9:0]        pixel_addr, line_addr;
  logic [4:0]        seg_addr;
  logic [1:0]        filter_select;
  logic [OFS_W-1:0]  correction_value;
  int                fail_count;
  int                cmp_count;

  dmst_timing uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .master_osc(master_osc),
    .picture_sync(picture_sync), .comp_above(comp_above), .pixel_clk(pixel_clk),
    .pll_div_resync(pll_div_resync), .tv_sync_reset(tv_sync_reset), .pixel_addr(pixel_addr),
    .line_addr(line_addr), .line_load_strobe(line_load_strobe),
    .line_counter_clear_strobe(line_counter_clear_strobe), .hblank(hblank), .vblank(vblank),
    .active_video(active_video), .field2(field2), .seg_clk(seg_clk), .seg_addr(seg_addr),
    .midgrey_force(midgrey_force), .out_sample_strobe(out_sample_strobe), .filter_select(filter_select),
    .correction_value(correction_value), .control_ram_load(control_ram_load),
    .field_midgrey_start(field_midgrey_start), .line_memory_write_inhibit(line_memory_write_inhibit)
  );

  dmst_far_model far (
    .pclk(pclk), .presetn(presetn), .sync_req(sync_req), .comp_level(comp_level),
    .master_osc(master_osc), .picture_sync(picture_sync), .comp_above(comp_above)
  );

  // ----------------------------------------
  // clock, compare and report
  // ----------------------------------------
  always #2.5 pclk = ~pclk;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
      fail_count++;
    end
  endtask

  task automatic give_verdict;
    $display("counts: %0d compares, %0d mismatches", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic timed_out(input string what);
    $display("unexpected %s: expected done, seen timeout", what);
    fail_count++;
    give_verdict();
  endtask

  // ----------------------------------------
  // apb master
  // ----------------------------------------
  // holds the request until pready is sampled high; the bound only cuts a hang
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16)
    begin
      @(posedge pclk);
      n++;
    end
    if (pready !== 1'b1)
      timed_out("apb ready");
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk("reset pixel", 0, pixel_addr);
    chk("reset line", 0, line_addr);
    chk("reset hblank", 1, hblank);
    chk("reset vblank", 1, vblank);
    chk("reset ram load", 1, control_ram_load);
    chk("reset field start", 1, field_midgrey_start);
    chk("reset ready", 0, pready);
    $display("test reset done");
  endtask

  task automatic t_regs;
    logic [31:0] rd;
    logic        err;
    for (int m = 0; m < 4; m++)
    begin
      apb(1'b1, REG_CTRL, m, rd, err);
      apb(1'b0, REG_CTRL, 0, rd, err);
      chk("ctrl readback", m, rd);
      chk("filter select", (m == 3) ? 0 : m, filter_select);
      apb(1'b0, REG_STATUS, 0, rd, err);
      chk("status filter", (m == 3) ? 0 : m, rd[5:4]);
    end
    apb(1'b1, 12'h00C, 32'hFFFFFFFF, rd, err);
    chk("unmapped write error", 1, err);
    apb(1'b0, 12'h00C, 0, rd, err);
    chk("unmapped read data", 0, rd);
    // read-only place: write must leave control untouched
    apb(1'b1, REG_STATUS, 32'h00000007, rd, err);
    apb(1'b0, REG_CTRL, 0, rd, err);
    chk("ctrl after status write", 3, rd);
    apb(1'b1, REG_CTRL, 32'h00000006, rd, err);
    $display("test registers done");
  endtask

  task automatic t_sync;
    int  n;
    logic tv_seen, pll_seen;
    tv_seen = 1'b0;
    pll_seen = 1'b0;
    @(posedge pclk);
    sync_req <= 1'b1;
    @(posedge pclk);
    sync_req <= 1'b0;
    for (n = 0; n < 8; n++)
    begin
      @(posedge pclk);
      if (tv_sync_reset === 1'b1)
      begin
        tv_seen = 1'b1;
        chk("pixel after sync", 0, pixel_addr);
        chk("line after sync", 0, line_addr);
      end
      if (pll_div_resync === 1'b1)
        pll_seen = 1'b1;
    end
    chk("tv sync reset pulse", 1, tv_seen);
    chk("divider resync pulse", 1, pll_seen);
    $display("test picture sync done");
  endtask

  // 128 mode with interpolation; comparator polarity alternates by line
  task automatic t_lines;
    int         cyc, strobes, segs;
    logic [9:0] pp, pl;
    logic [8:0] ce;
    cyc = 0;
    strobes = 0;
    segs = 0;
    pp = pixel_addr;
    pl = line_addr;
    while (line_addr < 24)
    begin
      @(posedge pclk);
      cyc++;
      if (cyc > 70000)
        timed_out("line run");
      comp_level <= line_addr[0];
      if (out_sample_strobe === 1'b1)
        strobes++;
      if (seg_clk === 1'b1)
        segs++;
      if (pixel_addr !== pp)
      begin
        chk("pixel step", (pp == 10'd611) ? 0 : pp + 1, pixel_addr);
        chk("line load strobe", pixel_addr == 10'd611, line_load_strobe);
        chk("hblank", pixel_addr < 10'd100, hblank);
        chk("active video", pixel_addr >= 10'd100, active_video);
        chk("midgrey force", pixel_addr < 10'd100, midgrey_force);
        if (pixel_addr < 10'd100)
          chk("blank address", line_addr[4:0], seg_addr);
        // entries up to the current line hold mid-grey plus or minus one
        ce = (seg_addr <= line_addr) ? (seg_addr[0] ? 9'h0FF : 9'h101) : 9'h100;
        if (pixel_addr >= 10'd100 && pixel_addr[1:0] == 2'b10)
          chk("active correction", ce, correction_value);
        if (pixel_addr == 10'd99)
          chk("offset step", line_addr[0] ? 9'h0FF : 9'h101, correction_value);
        if (pixel_addr == 10'd0)
        begin
          chk("line step", pl + 1, line_addr);
          chk("output samples per line", 128, strobes);
          chk("segment clocks per line", 4, segs);
          strobes = 0;
          segs = 0;
        end
        chk("ram load", line_addr < 10'd21, control_ram_load);
        chk("vblank", line_addr < 10'd21, vblank);
        chk("field start", line_addr == 10'd0, field_midgrey_start);
        chk("write inhibit", line_addr[0], line_memory_write_inhibit);
        chk("clear strobe", 0, line_counter_clear_strobe);
        pp = pixel_addr;
        pl = line_addr;
      end
    end
    $display("test lines done");
  endtask

  // steps edges until the line load strobe shows lvl, counting samples and segment clocks
  task automatic wait_lls(input logic lvl, inout int s, inout int g);
    int n;
    n = 0;
    while (line_load_strobe !== lvl && n < 3000)
    begin
      @(posedge pclk);
      n++;
      if (out_sample_strobe === 1'b1)
        s++;
      if (seg_clk === 1'b1)
        g++;
    end
    if (line_load_strobe !== lvl)
      timed_out("line load strobe");
  endtask

  // full and half rate over one whole line
  task automatic t_rates;
    logic [31:0] rd;
    logic        err;
    int          s, g;
    for (int m = 0; m < 2; m++)
    begin
      apb(1'b1, REG_CTRL, m, rd, err);
      s = 0;
      g = 0;
      wait_lls(1'b1, s, g);
      wait_lls(1'b0, s, g);
      s = 0;
      g = 0;
      wait_lls(1'b1, s, g);
      wait_lls(1'b0, s, g);
      chk("output samples per line", (m == 0) ? 512 : 256, s);
      chk("segment clocks per line", (m == 0) ? 16 : 8, g);
    end
    $display("test output rates done");
  endtask

  // second measurement of an entry steps from the stored value, not mid-grey
  task automatic t_restep;
    int n;
    n = 0;
    comp_level <= 1'b0;
    t_sync();
    while (pixel_addr !== 10'd99 && n < 1000)
    begin
      @(posedge pclk);
      n++;
    end
    if (pixel_addr !== 10'd99)
      timed_out("offset restep");
    chk("offset second step", 9'h102, correction_value);
    $display("test offset restep done");
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    sync_req = 1'b0;
    comp_level = 1'b0;
    fail_count = 0;
    cmp_count = 0;
    repeat (8) @(posedge pclk);
    t_reset();
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_sync();
    t_lines();
    t_rates();
    t_restep();
    give_verdict();
  end
endmodule
